// [hdl/system_reset_clock_sequencer.sv]
// Reset collector, recovery counter, clock gating and AXI4-Lite registers of the sequencer.
// Contract
// - Bus clock is source divided by four.
// - Power/low-supply reset: clocks held, pin low.
// - Stop exit waits 4096 or 32 cycles.
// - Wait mode stops CPU clocks only.
// - All resets assert internal reset; vector select.
// - Internal reset clears counter; external does not.
// - Each source sets its own cause flag.
// - Pin flag after 67 low cycles.
// - Internal reset: pin 32, then 32 more.
// - Power-on: pin low 4096+32, release 32 later.
// - Power-on sets its flag, clears others.
// - Watchdog overflow resets; input is asynchronous.
// - Watchdog disable is purely combinational.
// - Illegal opcode sets flag and resets.
// - Stop with stop_allow zero is illegal.
// - Only opcode fetch from unmapped address resets.
// - Low supply: flag, pin 4096+32, 32 more.
// - Monitor entry with erased vectors resets.
// - Recovery counter is thirteen bits wide.
// - Stop clears counter; short recovery selects 32.
// - Counter free-runs after reset states.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module system_reset_clock_sequencer
  import reset_seq_pkg::*;
#(
  parameter int PorHoldCyc = POR_HOLD_CYC,
  parameter int StopLongCyc = STOP_LONG_CYC
) (
  // Clock (selected clock source) and power-on reset.
  input wire logic clk,
  input wire logic rst,
  // Reset sources.
  input wire logic powerUpPulse,
  input wire logic lowSupplyTrip,
  input wire logic watchdogOverflow,
  input wire logic illegalOpcode,
  input wire logic unmappedAccess,
  input wire logic opcodeFetch,
  input wire logic monitorEntryReset,
  // CPU mode requests and mode straps.
  input wire logic stopInstr,
  input wire logic waitInstr,
  input wire logic wakeEvent,
  input wire logic monitorMode,
  input wire logic breakState,
  input wire logic resetPinHighVolt,
  input wire logic irqPinHighVolt,
  // Shared reset pin.
  input wire logic extResetPinIn,
  output logic extResetPinOut,
  output logic extResetPinDrvN,
  // Clock enables and reset outputs.
  output logic busClkEn,
  output logic cpuClkEn,
  output logic periphClkEn,
  output logic intResetSig,
  output logic watchdogDisable,
  output logic [15:0] resetVector,
  // AXI4-Lite write channels.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Last-count compare values, cut to the counter widths.
  localparam logic [CNT_W-1:0] PorLast = CNT_W'(PorHoldCyc - 1);
  localparam logic [CNT_W-1:0] StopLongLast = CNT_W'(StopLongCyc - 1);
  localparam logic [CNT_W-1:0] StopShortLast = CNT_W'(STOP_SHORT_CYC - 1);
  localparam logic [PHASE_W-1:0] PinDriveLast = PHASE_W'(PIN_DRIVE_CYC - 1);
  localparam logic [PHASE_W-1:0] IntTailLast = INT_TAIL_CYC[PHASE_W-1:0] - 7'h01;
  localparam logic [PHASE_W-1:0] PinMinLast = PHASE_W'(PIN_MIN_CYC - 1);

  // All state of the sequencer and its bus slave.
  typedef struct packed {
    seq_state_e st;
    logic [CNT_W-1:0] recCnt;
    logic [PHASE_W-1:0] phase;
    logic [1:0] div;
    logic [CAUSE_W-1:0] cause;
    logic stopAllow;
    logic shortRec;
    logic [1:0] pinSync;
    logic [1:0] wdogSync;
    logic [1:0] porSync;
    logic [1:0] lowvSync;
    logic [15:0] vector;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  // Registered copy and its next value.
  state_s s_reg;
  state_s s_next;

  // True in every state in which the internal reset is asserted.
  // Every reset source ends in one of these four states.
  function automatic logic inReset(input seq_state_e st);
    inReset = (st == ST_LONG_HOLD) || (st == ST_PIN_DRIVE) ||
              (st == ST_INT_TAIL) || (st == ST_EXT_HOLD);
  endfunction

  // True where the device itself pulls the reset pin low.
  function automatic logic drivesPin(input seq_state_e st);
    drivesPin = (st == ST_LONG_HOLD) || (st == ST_PIN_DRIVE);
  endfunction

  // Decoded events and bus helpers.
  logic busTick;
  logic wrTake;
  logic rdTake;
  logic badOpcodeEv;
  logic badFetchEv;
  logic wdogEv;
  logic longEv;
  logic [CAUSE_W-1:0] causeSet;
  logic [CAUSE_W-1:0] causeClr;
  logic [31:0] rdWord;
  logic rdHit;
  logic wrHit;
  logic stopRecDone;

  // Bus clock tick once every four source cycles.
  // The divider never stops, so the tick keeps its phase.
  assign busTick = (s_reg.div == BUS_DIV_LAST);

  // Gated clock enables and reset pin drive.
  assign busClkEn = busTick && !inReset(s_reg.st) && (s_reg.st != ST_STOPPED) &&
                    (s_reg.st != ST_STOP_REC);
  assign cpuClkEn = busTick && (s_reg.st == ST_RUN);
  assign periphClkEn = busTick && ((s_reg.st == ST_RUN) || (s_reg.st == ST_WAIT));
  assign intResetSig = inReset(s_reg.st);
  // Open-drain pin: data stays low, only the enable moves.
  assign extResetPinOut = 1'b0;
  assign extResetPinDrvN = !drivesPin(s_reg.st);
  assign resetVector = s_reg.vector;

  // Watchdog disable taken straight from the high-voltage detectors, no flops.
  assign watchdogDisable = (monitorMode && (resetPinHighVolt || irqPinHighVolt)) ||
                           (breakState && resetPinHighVolt);

  // Internal reset events.
  assign badOpcodeEv = illegalOpcode ||
                       (stopInstr && !s_reg.stopAllow && (s_reg.st == ST_RUN));
  assign badFetchEv = unmappedAccess && opcodeFetch;
  assign wdogEv = s_reg.wdogSync[1];
  // Power-on and low supply share the long hold.
  assign longEv = s_reg.porSync[1] || s_reg.lowvSync[1];

  // Stop recovery ends on the last count of the selected delay.
  assign stopRecDone = s_reg.shortRec ? (s_reg.recCnt == StopShortLast) :
                       (s_reg.recCnt == StopLongLast);

  // AXI handshakes: one write and one read at a time.
  // A new request waits while the last response stands.
  assign wrTake = s_axi_awvalid && s_axi_wvalid && !s_reg.bvalid;
  assign rdTake = s_axi_arvalid && !s_reg.rvalid;
  assign s_axi_awready = wrTake;
  assign s_axi_wready = wrTake;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;

  // Read multiplexer over the three registers.
  // Unmapped addresses read zero with an error response.
  always_comb begin
    rdHit = 1'b1;
    rdWord = 32'h0000_0000;
    unique case (s_axi_araddr)
      CAUSE_ADDR: rdWord[CAUSE_W-1:0] = s_reg.cause;
      CONFIG_ADDR: begin
        rdWord[CFG_STOP_ALLOW] = s_reg.stopAllow;
        rdWord[CFG_SHORT_REC] = s_reg.shortRec;
      end
      STATUS_ADDR: begin
        rdWord[STAT_STATE_LSB +: $bits(seq_state_e)] = s_reg.st;
        rdWord[STAT_CNT_LSB +: CNT_W] = s_reg.recCnt;
      end
      default: rdHit = 1'b0;
    endcase
  end

  // Write decode and cause flag updates; a set in the same cycle beats a clear.
  always_comb begin
    wrHit = (s_axi_awaddr == CAUSE_ADDR) || (s_axi_awaddr == CONFIG_ADDR) ||
            (s_axi_awaddr == STATUS_ADDR);
    causeClr = '0;
    if (wrTake && (s_axi_awaddr == CAUSE_ADDR) && s_axi_wstrb[0]) begin
      causeClr = s_axi_wdata[CAUSE_W-1:0];
    end
    causeSet = '0;
    causeSet[CAUSE_LOWV] = s_reg.lowvSync[1];
    // Internal sources count only outside a reset sequence.
    if (!longEv && !inReset(s_reg.st)) begin
      causeSet[CAUSE_WDOG] = wdogEv;
      causeSet[CAUSE_OPC] = badOpcodeEv;
      causeSet[CAUSE_ADR] = badFetchEv;
      causeSet[CAUSE_MON] = monitorEntryReset;
    end
    // The pin flag needs the full minimum low time.
    if (!longEv && (s_reg.st == ST_EXT_HOLD) && (s_reg.phase == PinMinLast)) begin
      causeSet[CAUSE_PIN] = 1'b1;
    end
  end

  // Sequencer, counters, synchronisers and bus slave next state.
  always_comb begin
    s_next = s_reg;
    s_next.div = s_reg.div + 2'h1;
    s_next.pinSync = {s_reg.pinSync[0], extResetPinIn};
    s_next.wdogSync = {s_reg.wdogSync[0], watchdogOverflow};
    s_next.porSync = {s_reg.porSync[0], powerUpPulse};
    s_next.lowvSync = {s_reg.lowvSync[0], lowSupplyTrip};
    s_next.vector = monitorMode ? VEC_MONITOR : VEC_USER;
    s_next.cause = (s_reg.cause & ~causeClr) | causeSet;
    s_next.recCnt = s_reg.recCnt + 13'h0001;
    s_next.phase = s_reg.phase;
    if (longEv) begin
      s_next.st = ST_LONG_HOLD;
      s_next.recCnt = '0;
      if (s_reg.porSync[1]) begin
        s_next.cause = CAUSE_POR_ONLY;
      end
    end else begin
      unique case (s_reg.st)
        // Running, waiting and stopped states watch for resets.
        ST_RUN, ST_WAIT, ST_STOPPED, ST_STOP_REC: begin
          // Internal sources win over the pin and mode requests.
          if (wdogEv || badOpcodeEv || badFetchEv || monitorEntryReset) begin
            s_next.st = ST_PIN_DRIVE;
            s_next.recCnt = '0;
            s_next.phase = '0;
          end else if (!s_reg.pinSync[1]) begin
            // An outside chip holds the pin; the counter runs on.
            s_next.st = ST_EXT_HOLD;
            s_next.phase = '0;
          end else if (s_reg.st == ST_RUN) begin
            // Stop and wait are honoured only while running.
            // A refused stop has already taken the reset branch.
            if (stopInstr && s_reg.stopAllow) begin
              s_next.st = ST_STOPPED;
              s_next.recCnt = '0;
            end else if (waitInstr) begin
              s_next.st = ST_WAIT;
            end
          end else if (s_reg.st == ST_WAIT) begin
            // Any wake event restarts the CPU clocks.
            if (wakeEvent) begin
              s_next.st = ST_RUN;
            end
          end else if (s_reg.st == ST_STOPPED) begin
            // The counter stays clear until the wake-up.
            s_next.recCnt = '0;
            if (wakeEvent) begin
              s_next.st = ST_STOP_REC;
            end
          end else if (stopRecDone) begin
            s_next.st = ST_RUN;
          end
        end
        // Long hold after power-on or low supply.
        ST_LONG_HOLD: begin
          if (s_reg.recCnt == PorLast) begin
            s_next.st = ST_INT_TAIL;
            s_next.phase = '0;
          end
        end
        // Internal source: the device pulls the pin.
        ST_PIN_DRIVE: begin
          s_next.phase = s_reg.phase + 7'h01;
          if (s_reg.phase == PinDriveLast) begin
            s_next.st = ST_INT_TAIL;
            s_next.phase = '0;
          end
        end
        // Pin released; the internal reset stays on.
        ST_INT_TAIL: begin
          s_next.phase = s_reg.phase + 7'h01;
          if (s_reg.phase == IntTailLast) begin
            s_next.st = ST_RUN;
          end
        end
        // Outside hold; the phase saturates at the flag count.
        ST_EXT_HOLD: begin
          if (s_reg.phase != PinMinLast) begin
            s_next.phase = s_reg.phase + 7'h01;
          end
          if (s_reg.pinSync[1]) begin
            s_next.st = ST_INT_TAIL;
            s_next.phase = '0;
          end
        end
      endcase
    end
    // Write channel: configuration bits and write response.
    // Only byte lane 0 carries register bits.
    if (wrTake) begin
      s_next.bvalid = 1'b1;
      s_next.bresp = wrHit ? RESP_OKAY : RESP_SLVERR;
      if ((s_axi_awaddr == CONFIG_ADDR) && s_axi_wstrb[0]) begin
        s_next.stopAllow = s_axi_wdata[CFG_STOP_ALLOW];
        s_next.shortRec = s_axi_wdata[CFG_SHORT_REC];
      end
    end else if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    // Every reset sequence puts the configuration back to its defaults.
    // The reset owns the register, so a write in reset is lost.
    if (inReset(s_reg.st)) begin
      s_next.stopAllow = CFG_STOP_ALLOW_RST;
      s_next.shortRec = CFG_SHORT_REC_RST;
    end
    // Read channel.
    if (rdTake) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rdWord;
      s_next.rresp = rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  // State register; reset starts the power-on hold with only the power-on flag set.
  // The pin synchroniser starts high, so no false pin reset follows.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg.st <= ST_LONG_HOLD;
      s_reg.recCnt <= '0;
      s_reg.phase <= '0;
      s_reg.div <= '0;
      s_reg.cause <= CAUSE_POR_ONLY;
      s_reg.stopAllow <= CFG_STOP_ALLOW_RST;
      s_reg.shortRec <= CFG_SHORT_REC_RST;
      s_reg.pinSync <= 2'h3;
      s_reg.wdogSync <= '0;
      s_reg.porSync <= '0;
      s_reg.lowvSync <= '0;
      s_reg.vector <= VEC_USER;
      s_reg.bvalid <= 1'b0;
      s_reg.bresp <= RESP_OKAY;
      s_reg.rvalid <= 1'b0;
      s_reg.rdata <= '0;
      s_reg.rresp <= RESP_OKAY;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule
`default_nettype wire

// [hdl/reset_seq_pkg.sv]
// Package with constants, register map and state codes of the reset and clock sequencer.
package reset_seq_pkg;
  // Register byte addresses on the AXI4-Lite bus.
  localparam logic [3:0] CAUSE_ADDR = 4'h0;
  localparam logic [3:0] CONFIG_ADDR = 4'h4;
  localparam logic [3:0] STATUS_ADDR = 4'h8;
  localparam int ADDR_W = 4;
  // Reset cause flag positions.
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_PIN = 1;
  localparam int CAUSE_WDOG = 2;
  localparam int CAUSE_OPC = 3;
  localparam int CAUSE_ADR = 4;
  localparam int CAUSE_LOWV = 5;
  localparam int CAUSE_MON = 6;
  localparam int CAUSE_W = 7;
  localparam logic [6:0] CAUSE_POR_ONLY = 7'h01;
  // Configuration fields and reset values.
  localparam int CFG_STOP_ALLOW = 0;
  localparam int CFG_SHORT_REC = 1;
  localparam logic CFG_STOP_ALLOW_RST = 1'b1;
  localparam logic CFG_SHORT_REC_RST = 1'b0;
  // Status fields.
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_CNT_LSB = 16;
  // Timing counts in selected-source clock cycles.
  localparam int CNT_W = 13;
  localparam int PHASE_W = 7;
  localparam int POR_HOLD_CYC = 4096 + 32;
  localparam int STOP_LONG_CYC = 4096;
  localparam int STOP_SHORT_CYC = 32;
  localparam int PIN_DRIVE_CYC = 32;
  localparam int INT_TAIL_CYC = 32;
  localparam int PIN_MIN_CYC = 67;
  localparam logic [1:0] BUS_DIV_LAST = 2'h3;
  // Reset vector addresses.
  localparam logic [15:0] VEC_USER = 16'hFFFE;
  localparam logic [15:0] VEC_MONITOR = 16'hFEFE;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_WAIT = 3'b001,
    ST_STOPPED = 3'b010,
    ST_STOP_REC = 3'b011,
    ST_LONG_HOLD = 3'b100,
    ST_PIN_DRIVE = 3'b101,
    ST_INT_TAIL = 3'b110,
    ST_EXT_HOLD = 3'b111
  } seq_state_e;
endpackage

// [test/reset_pin_partner.sv]
// Model of an outside chip that shares the open-drain reset pin.
`timescale 1ns/10ps
`default_nettype none
module reset_pin_partner (
  // Clock of the selected source.
  input wire logic clk,
  // Device pull-down, low while the device drives the pin.
  input wire logic devDrvN,
  // Resolved pin level seen by every party.
  output logic pinLevel
);
  logic pullLow = 1'b0;
  // The pin has a pull-up, so it reads high unless a party pulls it down.
  assign pinLevel = !(pullLow || !devDrvN);
  // Holds the pin low for the given count, then lets the pull-up win.
  task automatic pull_low(input int cycles);
    pullLow <= 1'b1;
    repeat (cycles) @(posedge clk);
    pullLow <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [test/seq_checker_assertions.sv]
// Port-level assertions of the reset and clock sequencer.
`timescale 1ns/10ps
`default_nettype none
module seq_checker
  import reset_seq_pkg::*;
#(
  parameter int PorHoldCyc = POR_HOLD_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Watched inputs.
  input wire logic illegalOpcode,
  input wire logic unmappedAccess,
  input wire logic opcodeFetch,
  input wire logic monitorMode,
  input wire logic breakState,
  input wire logic resetPinHighVolt,
  input wire logic irqPinHighVolt,
  // Watched outputs.
  input wire logic extResetPinDrvN,
  input wire logic busClkEn,
  input wire logic cpuClkEn,
  input wire logic periphClkEn,
  input wire logic intResetSig,
  input wire logic watchdogDisable,
  input wire logic [15:0] resetVector
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [12:0] lowCnt;
  // Counts the cycles for which the device pulls the pin low.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowCnt <= 13'h0;
    end else begin
      lowCnt <= extResetPinDrvN ? 13'h0 : lowCnt + 13'h1;
    end
  end
  // Internal reset holds for the first 8 cycles after the pin is let go and ends after exactly 32.
  sequence s_tail;
    intResetSig[*8] ##24 intResetSig ##1 !intResetSig;
  endsequence
  property p_div;
    busClkEn |=> !busClkEn[*3];
  endproperty
  a_div: assert property (p_div) else $error("bus enable faster than 1 in 4");
  property p_cpu;
    cpuClkEn |-> periphClkEn && busClkEn;
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu clock without bus clock");
  property p_hold;
    intResetSig |-> !busClkEn && !periphClkEn;
  endproperty
  a_hold: assert property (p_hold) else $error("clocks run in reset");
  property p_pin;
    !extResetPinDrvN |-> intResetSig;
  endproperty
  a_pin: assert property (p_pin) else $error("pin driven without reset");
  property p_len;
    $rose(extResetPinDrvN) |-> lowCnt == 32 || lowCnt == PorHoldCyc;
  endproperty
  a_len: assert property (p_len) else $error("pin drive length wrong");
  property p_tail;
    $rose(extResetPinDrvN) |-> s_tail;
  endproperty
  a_tail: assert property (p_tail) else $error("reset tail length wrong");
  property p_opc;
    illegalOpcode && !intResetSig |=> !extResetPinDrvN;
  endproperty
  a_opc: assert property (p_opc) else $error("bad opcode did not reset");
  property p_fetch;
    unmappedAccess && opcodeFetch && !intResetSig |=> !extResetPinDrvN;
  endproperty
  a_fetch: assert property (p_fetch) else $error("bad fetch did not reset");
  property p_wd;
    watchdogDisable == (monitorMode && (resetPinHighVolt || irqPinHighVolt)
      || breakState && resetPinHighVolt);
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog disable wrong");
  property p_vec;
    !$past(rst) |-> resetVector == ($past(monitorMode) ? VEC_MONITOR : VEC_USER);
  endproperty
  a_vec: assert property (p_vec) else $error("reset vector wrong");
endmodule
`default_nettype wire

// [test/system_reset_clock_sequencer_tb_top.sv]
// Self-checking bench of the reset and clock sequencer.
`timescale 1ns/10ps
`default_nettype none
module system_reset_clock_sequencer_tb_top
  import reset_seq_pkg::*;
;
  localparam int StopLong = 64;
  logic clk, rst, powerUpPulse, lowSupplyTrip, watchdogOverflow, illegalOpcode;
  logic unmappedAccess, opcodeFetch, monitorEntryReset, stopInstr, waitInstr, wakeEvent;
  logic monitorMode, breakState, resetPinHighVolt, irqPinHighVolt, extResetPinIn;
  logic extResetPinOut, extResetPinDrvN, busClkEn, cpuClkEn, periphClkEn, intResetSig;
  logic watchdogDisable, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] resetVector;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, cpuN, perN, msk;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [12:0] c1;
  int fail_count = 0, num_checks = 0, seed = 75, n, cyc = 0, t1, d;
  logic [9:0] srcTab [10] = '{10'h040, 10'h030, 10'h008, 10'h080, 10'h020, 10'h004,
    10'h100, 10'h200, 10'h000, 10'h000};
  int expTab [10] = '{1 << CAUSE_OPC, 1 << CAUSE_ADR, 1 << CAUSE_MON, 1 << CAUSE_WDOG, 0,
    1 << CAUSE_OPC, 1 << CAUSE_LOWV, 1 << CAUSE_POR, 1 << CAUSE_PIN, 0};
  // Design with shortened long counts, and the chip sharing its pin.
  system_reset_clock_sequencer #(.PorHoldCyc(40), .StopLongCyc(StopLong)) i_dut (
    .clk(clk), .rst(rst), .powerUpPulse(powerUpPulse), .lowSupplyTrip(lowSupplyTrip),
    .watchdogOverflow(watchdogOverflow), .illegalOpcode(illegalOpcode),
    .unmappedAccess(unmappedAccess), .opcodeFetch(opcodeFetch),
    .monitorEntryReset(monitorEntryReset), .stopInstr(stopInstr), .waitInstr(waitInstr),
    .wakeEvent(wakeEvent), .monitorMode(monitorMode), .breakState(breakState),
    .resetPinHighVolt(resetPinHighVolt), .irqPinHighVolt(irqPinHighVolt),
    .extResetPinIn(extResetPinIn), .extResetPinOut(extResetPinOut),
    .extResetPinDrvN(extResetPinDrvN), .busClkEn(busClkEn), .cpuClkEn(cpuClkEn),
    .periphClkEn(periphClkEn), .intResetSig(intResetSig), .watchdogDisable(watchdogDisable),
    .resetVector(resetVector), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  reset_pin_partner i_partner (.clk(clk), .devDrvN(extResetPinDrvN), .pinLevel(extResetPinIn));
  // Clock and cycle stamp.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tmo();
    fail_count++;
    give_verdict();
  endtask
  // Drives a set of sources and waits one cycle; they hold until the next call.
  task automatic src(input logic [9:0] v);
    {powerUpPulse, lowSupplyTrip, watchdogOverflow, illegalOpcode, unmappedAccess,
      opcodeFetch, monitorEntryReset, stopInstr, waitInstr, wakeEvent} <= v;
    @(posedge clk);
  endtask
  // Register write; address and data are offered together.
  task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(s_axi_awready && s_axi_wready) && n < 99);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (!s_axi_bvalid && n < 99);
    rsp = s_axi_bresp;
    if (n >= 99) tmo();
  endtask
  task automatic axr(input logic [ADDR_W-1:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!s_axi_arready && n < 99);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (!s_axi_rvalid && n < 99);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    if (n >= 99) tmo();
  endtask
  // Waits for a reset sequence to start, or not, and to finish.
  task automatic waitRst(input logic hit);
    n = 0;
    while (!intResetSig && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(intResetSig, hit);
    n = 0;
    while (intResetSig && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) tmo();
  endtask
  // Main sequence.
  initial begin
    rst = 1'b1;
    {monitorMode, breakState, resetPinHighVolt, irqPinHighVolt} = 4'h0;
    {powerUpPulse, lowSupplyTrip, watchdogOverflow, illegalOpcode, unmappedAccess} = 5'h0;
    {opcodeFetch, monitorEntryReset, stopInstr, waitInstr, wakeEvent} = 5'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 5'h03;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 32'h0, 4'hF};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    chk({extResetPinOut, extResetPinDrvN}, 32'h0);
    waitRst(1'b1);
    axr(CAUSE_ADDR);
    chk(rd, CAUSE_POR_ONLY);
    axr(CONFIG_ADDR);
    chk(rd, {CFG_SHORT_REC_RST, CFG_STOP_ALLOW_RST});
    axw(CAUSE_ADDR, 32'h7F);
    axr(4'hC);
    chk(rsp, RESP_SLVERR);
    axr(STATUS_ADDR);
    c1 = rd[28:16];
    repeat (100) @(posedge clk);
    axr(STATUS_ADDR);
    chk(13'(rd[28:16] - c1), 102);
    repeat (50) begin
      @(posedge clk);
      {monitorMode, breakState, resetPinHighVolt, irqPinHighVolt} <= 4'($random(seed));
      @(negedge clk);
      chk(watchdogDisable, monitorMode & (resetPinHighVolt | irqPinHighVolt)
        | breakState & resetPinHighVolt);
    end
    @(posedge clk);
    {monitorMode, breakState, resetPinHighVolt, irqPinHighVolt} <= 4'h0;
    src(10'h002);
    src(10'h000);
    {cpuN, perN} = 64'h0;
    repeat (40) begin
      @(posedge clk);
      cpuN += cpuClkEn;
      perN += periphClkEn;
    end
    chk(cpuN, 0);
    chk(perN, 10);
    src(10'h001);
    for (int s = 0; s < 2; s++) begin
      axw(CONFIG_ADDR, 32'(s * 2 + 1));
      src(10'h004);
      src(10'h000);
      axr(STATUS_ADDR);
      chk(rd[2:0], ST_STOPPED);
      src(10'h001);
      src(10'h000);
      d = s ? 32 : StopLong;
      n = 0;
      while (!busClkEn && n < 200) begin
        @(posedge clk);
        n++;
      end
      chk(n >= d - 2 && n <= d + 6, 1);
    end
    for (int i = 0; i < 10; i++) begin
      if (i == 5) axw(CONFIG_ADDR, 32'h0);
      axr(STATUS_ADDR);
      c1 = rd[28:16];
      t1 = cyc;
      src(srcTab[i]);
      src(10'h000);
      if (i >= 8) i_partner.pull_low(i == 8 ? 80 : 20);
      waitRst(i != 4);
      axr(STATUS_ADDR);
      chk(13'(rd[28:16] - c1) == 13'(cyc - t1), i == 4 || i >= 8);
      axr(CAUSE_ADDR);
      msk = (i == 6) ? expTab[i] : 32'h7F;
      chk(rd & msk, expTab[i]);
      axw(CAUSE_ADDR, 32'h7F);
      if (i == 5) axr(CONFIG_ADDR);
      if (i == 5) chk(rd, 1);
    end
    give_verdict();
  end
endmodule
bind system_reset_clock_sequencer seq_checker #(.PorHoldCyc(PorHoldCyc)) i_chk (
  .clk(clk), .rst(rst), .illegalOpcode(illegalOpcode), .unmappedAccess(unmappedAccess),
  .opcodeFetch(opcodeFetch), .monitorMode(monitorMode), .breakState(breakState),
  .resetPinHighVolt(resetPinHighVolt), .irqPinHighVolt(irqPinHighVolt),
  .extResetPinDrvN(extResetPinDrvN), .busClkEn(busClkEn), .cpuClkEn(cpuClkEn),
  .periphClkEn(periphClkEn), .intResetSig(intResetSig), .watchdogDisable(watchdogDisable),
  .resetVector(resetVector));
`default_nettype wire
